// ===== src/capture_defines.svh
// Register map, field positions, mode codes and counts of the input capture channel.
//
// What this block does
// RULE1: Clearing the enable bit resets and stops the channel, silences its interrupt and frees its settings for change.
// RULE2: With idle-stop set the channel halts while the processor idles, and with it clear the channel keeps running.
// RULE3: First-edge select matters only in mode 110, where 1 takes the first capture on a rising edge and 0 on a falling one.
// RULE4: Wide capture select takes 32-bit values from the joined timer when set and 16-bit values from one timer when clear.
// RULE5: Counter source select takes the secondary timer at 0 and the primary at 1, and does nothing in 32-bit capture.
// RULE6: Interrupt decimation 00, 01, 10 and 11 raise one interrupt per one, two, three and four capture events.
// RULE7: A read-only overflow flag reads 1 once a capture overflow has happened and 0 otherwise.
// RULE8: A read-only buffer-not-empty bit reads 1 while a captured value waits to be read and 0 when none does.
// RULE9: Mode 000 disables capture and takes no values.
// RULE10: Mode 001 captures on every edge, rising and falling.
// RULE11: Mode 010 captures on every falling edge and mode 011 on every rising edge.
// RULE12: Mode 100 captures on every fourth rising edge and mode 101 on every sixteenth.
// RULE13: Mode 110 captures first on the edge that first-edge select names and then on every edge.
// RULE14: Mode 111 raises an interrupt on edges without capturing, and only while the processor sleeps or idles.
// RULE15: Captured values queue in a small FIFO whose oldest entry each result read returns and removes.
// RULE16: Overflow is set by a capture into a full buffer and cleared by disabling the channel or draining the buffer.
// RULE17: The decimation counter restarts when the channel is disabled or the decimation field changes.
`ifndef CAPTURE_DEFINES_SVH
`define CAPTURE_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CAP_ADDR_W 12
`define CAP_CTRL_OFS 12'h000
`define CAP_RESULT_OFS 12'h004
`define CAP_EVENT_OFS 12'h008
`define CAP_MASK_OFS 12'h00c

// ****************************************************************
// Control register fields
// ****************************************************************
`define CAP_ON_BIT 15
`define CAP_ISTOP_BIT 13
`define CAP_FIRST_BIT 9
`define CAP_WIDE_BIT 8
`define CAP_TMR_BIT 7
`define CAP_DEC_MSB 6
`define CAP_DEC_LSB 5
`define CAP_OVF_BIT 4
`define CAP_BNE_BIT 3
`define CAP_MODE_MSB 2
`define CAP_MODE_LSB 0
`define CAP_CTRL_RESET 10'h000

// ****************************************************************
// Mode codes
// ****************************************************************
`define CAP_MODE_OFF 3'b000
`define CAP_MODE_BOTH 3'b001
`define CAP_MODE_FALL 3'b010
`define CAP_MODE_RISE 3'b011
`define CAP_MODE_PRE4 3'b100
`define CAP_MODE_PRE16 3'b101
`define CAP_MODE_FIRST 3'b110
`define CAP_MODE_INTONLY 3'b111

// ****************************************************************
// Event bits, counts and widths
// ****************************************************************
`define CAP_EV_W 3
`define CAP_EV_RESET 3'h0
`define CAP_PRE4_LAST 4'h3
`define CAP_PRE16_LAST 4'hf
`define CAP_PRE_RESET 4'h0
`define CAP_DEC_RESET 2'h0
`define CAP_FIFO_DEPTH 4
`define CAP_HALF_W 16
`define CAP_WORD_W 32
`define CAP_HALF_ZERO 16'h0000
`define CAP_WORD_ZERO 32'h0000_0000

`endif

// ===== src/capture_fifo.sv
// Small first-in first-out store for captured timer values.
`timescale 1ns/1ps
module capture_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] din,
    input wire logic pop,
    output logic [WIDTH-1:0] dout,
    output logic full,
    output logic empty,
    output logic last
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] count_q;
    logic do_push;
    logic do_pop;

    if (DEPTH < 2 || DEPTH > 256) begin : g_check
        $error("capture_fifo depth must lie between 2 and 256");
    end

    assign full = (count_q == CW'(DEPTH));
    assign empty = (count_q == '0);
    assign last = (count_q == CW'(1));
    assign dout = mem[rd_q];
    assign do_push = push & ~full;
    assign do_pop = pop & ~empty;

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    always_ff @(posedge pclk) begin
        if (clk_en && do_push) begin
            mem[wr_q] <= din;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else if (clk_en) begin
            if (flush) begin
                wr_q <= '0;
                rd_q <= '0;
                count_q <= '0;
            end else begin
                if (do_push) begin
                    wr_q <= wrap_inc(wr_q);
                end
                if (do_pop) begin
                    rd_q <= wrap_inc(rd_q);
                end
                if (do_push && !do_pop) begin
                    count_q <= count_q + CW'(1);
                end else if (do_pop && !do_push) begin
                    count_q <= count_q - CW'(1);
                end
            end
        end
    end
endmodule // capture_fifo

// ===== src/capture_pkg.sv
// Types shared by the input capture channel files.
package capture_pkg;

    // Software-visible settings of the channel.
    typedef struct packed {
        logic on;
        logic istop;
        logic fsel;
        logic wide;
        logic tmr;
        logic [1:0] dec;
        logic [2:0] mode;
    } ctrl_t;

    // Sticky event bits, also the layout of the mask register.
    typedef struct packed {
        logic edge_only;
        logic overflow;
        logic capture;
    } event_t;

endpackage

// ===== src/input_capture_channel.sv
// Input capture channel with an APB register slave.
`timescale 1ns/1ps
`include "capture_defines.svh"
module input_capture_channel #(
    parameter int DEPTH = `CAP_FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`CAP_ADDR_W-1:0] paddr,
    input wire logic [`CAP_WORD_W-1:0] pwdata,
    output logic [`CAP_WORD_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_pin,
    input wire logic [`CAP_HALF_W-1:0] primary_count,
    input wire logic [`CAP_HALF_W-1:0] secondary_count,
    input wire logic [`CAP_WORD_W-1:0] wide_count,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    output logic irq
);
    import capture_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    capture_pkg::ctrl_t ctrl_q;
    capture_pkg::event_t ev_q;
    capture_pkg::event_t mask_q;
    capture_pkg::event_t ev_set;
    capture_pkg::event_t ev_clr;
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;
    logic rise;
    logic fall;
    logic running;
    logic asleep;
    logic [3:0] pre_q;
    logic [3:0] pre_d;
    logic first_q;
    logic first_d;
    logic cap_fire;
    logic edge_fire;
    logic [1:0] dec_q;
    logic dec_hit;
    logic ovf_q;
    logic [`CAP_WORD_W-1:0] cap_value;
    logic [`CAP_WORD_W-1:0] fifo_dout;
    logic fifo_full;
    logic fifo_empty;
    logic fifo_last;
    logic fifo_pop;
    logic access;
    logic done;
    logic wr_done;
    logic rd_done;
    logic hit_ctrl;
    logic hit_result;
    logic hit_event;
    logic hit_mask;
    logic hit_any;
    logic ici_change;
    logic [`CAP_WORD_W-1:0] rdata_d;
    logic [`CAP_WORD_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    if (DEPTH < 2 || DEPTH > 256) begin : g_check
        $error("input_capture_channel depth must lie between 2 and 256");
    end

    // ****************************************************************
    // Pin synchroniser and edge detection
    // ****************************************************************
    // The third stage only remembers the settled level for edge detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else if (clk_en) begin
            pin_s1_q <= capture_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign rise = pin_s2_q & ~pin_s3_q;
    assign fall = ~pin_s2_q & pin_s3_q;

    // ****************************************************************
    // Run conditions
    // ****************************************************************
    assign running = ctrl_q.on & ~(ctrl_q.istop & cpu_idle); // [RULE1] [RULE2]
    assign asleep = cpu_idle | cpu_sleep;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // Every transfer takes one wait state, so data and error are from flops.
    assign access = psel & penable & ~pready_q;
    assign done = psel & penable & pready_q;
    assign wr_done = done & pwrite;
    assign rd_done = done & ~pwrite;
    assign hit_ctrl = (paddr == `CAP_CTRL_OFS);
    assign hit_result = (paddr == `CAP_RESULT_OFS);
    assign hit_event = (paddr == `CAP_EVENT_OFS);
    assign hit_mask = (paddr == `CAP_MASK_OFS);
    assign hit_any = hit_ctrl | hit_result | hit_event | hit_mask;

    // ****************************************************************
    // Control register
    // ****************************************************************
    // While enabled only the enable bit itself can be written.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CAP_CTRL_RESET;
        end else if (clk_en && wr_done && hit_ctrl) begin
            ctrl_q.on <= pwdata[`CAP_ON_BIT];
            if (!ctrl_q.on) begin // [RULE1]
                ctrl_q.istop <= pwdata[`CAP_ISTOP_BIT];
                ctrl_q.fsel <= pwdata[`CAP_FIRST_BIT];
                ctrl_q.wide <= pwdata[`CAP_WIDE_BIT];
                ctrl_q.tmr <= pwdata[`CAP_TMR_BIT];
                ctrl_q.dec <= pwdata[`CAP_DEC_MSB:`CAP_DEC_LSB];
                ctrl_q.mode <= pwdata[`CAP_MODE_MSB:`CAP_MODE_LSB];
            end
        end
    end

    assign ici_change = wr_done & hit_ctrl & ~ctrl_q.on & (pwdata[`CAP_DEC_MSB:`CAP_DEC_LSB] != ctrl_q.dec);

    // ****************************************************************
    // Capture decision
    // ****************************************************************
    always_comb begin
        cap_fire = 1'b0;
        edge_fire = 1'b0;
        pre_d = pre_q;
        first_d = first_q;
        if (running) begin
            case (ctrl_q.mode)
                `CAP_MODE_OFF: begin
                    cap_fire = 1'b0; // [RULE9]
                end
                `CAP_MODE_BOTH: begin
                    cap_fire = rise | fall; // [RULE10]
                end
                `CAP_MODE_FALL: begin
                    cap_fire = fall; // [RULE11]
                end
                `CAP_MODE_RISE: begin
                    cap_fire = rise; // [RULE11]
                end
                `CAP_MODE_PRE4: begin
                    if (rise) begin
                        cap_fire = (pre_q == `CAP_PRE4_LAST); // [RULE12]
                        pre_d = cap_fire ? `CAP_PRE_RESET : pre_q + 4'h1;
                    end
                end
                `CAP_MODE_PRE16: begin
                    if (rise) begin
                        cap_fire = (pre_q == `CAP_PRE16_LAST); // [RULE12]
                        pre_d = cap_fire ? `CAP_PRE_RESET : pre_q + 4'h1;
                    end
                end
                `CAP_MODE_FIRST: begin
                    if (first_q) begin
                        cap_fire = rise | fall; // [RULE13]
                    end else if (ctrl_q.fsel ? rise : fall) begin // [RULE3]
                        cap_fire = 1'b1;
                        first_d = 1'b1;
                    end
                end
                `CAP_MODE_INTONLY: begin
                    // Outside sleep or idle this mode is unsupported and stays quiet.
                    edge_fire = (rise | fall) & asleep; // [RULE14]
                end
                default: begin
                    cap_fire = 1'b0;
                end
            endcase
        end
    end

    // Prescaler and first-edge state restart whenever the channel is off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= `CAP_PRE_RESET;
            first_q <= 1'b0;
        end else if (clk_en) begin
            if (!ctrl_q.on) begin // [RULE1]
                pre_q <= `CAP_PRE_RESET;
                first_q <= 1'b0;
            end else begin
                pre_q <= pre_d;
                first_q <= first_d;
            end
        end
    end

    // ****************************************************************
    // Capture value and buffer
    // ****************************************************************
    // The source select is ignored in wide mode because the joined pair is fixed.
    assign cap_value = ctrl_q.wide ? wide_count : // [RULE4] [RULE5]
        {`CAP_HALF_ZERO, (ctrl_q.tmr ? primary_count : secondary_count)};

    assign fifo_pop = rd_done & hit_result & ~fifo_empty; // [RULE15]

    capture_fifo #(
        .WIDTH(`CAP_WORD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .flush(~ctrl_q.on),
        .push(cap_fire),
        .din(cap_value),
        .pop(fifo_pop),
        .dout(fifo_dout),
        .full(fifo_full),
        .empty(fifo_empty),
        .last(fifo_last)
    );

    // ****************************************************************
    // Overflow flag
    // ****************************************************************
    // A new capture into a full buffer is dropped; the stored values survive.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
        end else if (clk_en) begin
            if (!ctrl_q.on) begin
                ovf_q <= 1'b0; // [RULE16]
            end else if (cap_fire && fifo_full) begin
                ovf_q <= 1'b1; // [RULE7] [RULE16]
            end else if (fifo_pop && fifo_last) begin
                ovf_q <= 1'b0; // [RULE16]
            end
        end
    end

    // ****************************************************************
    // Interrupt decimation
    // ****************************************************************
    assign dec_hit = cap_fire & (dec_q == ctrl_q.dec); // [RULE6]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_q <= `CAP_DEC_RESET;
        end else if (clk_en) begin
            if (!ctrl_q.on || ici_change) begin
                dec_q <= `CAP_DEC_RESET; // [RULE17]
            end else if (dec_hit) begin
                dec_q <= `CAP_DEC_RESET; // [RULE6]
            end else if (cap_fire) begin
                dec_q <= dec_q + 2'h1;
            end
        end
    end

    // ****************************************************************
    // Event status and mask
    // ****************************************************************
    // A set in the same cycle as a write-one clear wins.
    assign ev_set = '{edge_only: edge_fire, overflow: cap_fire & fifo_full, capture: dec_hit};
    assign ev_clr = (wr_done && hit_event) ? capture_pkg::event_t'(pwdata[`CAP_EV_W-1:0]) : `CAP_EV_RESET;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_q <= `CAP_EV_RESET;
        end else if (clk_en) begin
            ev_q <= (ev_q & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= `CAP_EV_RESET;
        end else if (clk_en && wr_done && hit_mask) begin
            mask_q <= capture_pkg::event_t'(pwdata[`CAP_EV_W-1:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= ctrl_q.on & (|(ev_q & mask_q)); // [RULE1]
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_comb begin
        rdata_d = `CAP_WORD_ZERO;
        if (hit_ctrl) begin
            rdata_d[`CAP_ON_BIT] = ctrl_q.on;
            rdata_d[`CAP_ISTOP_BIT] = ctrl_q.istop;
            rdata_d[`CAP_FIRST_BIT] = ctrl_q.fsel;
            rdata_d[`CAP_WIDE_BIT] = ctrl_q.wide;
            rdata_d[`CAP_TMR_BIT] = ctrl_q.tmr;
            rdata_d[`CAP_DEC_MSB:`CAP_DEC_LSB] = ctrl_q.dec;
            rdata_d[`CAP_OVF_BIT] = ovf_q; // [RULE7]
            rdata_d[`CAP_BNE_BIT] = ~fifo_empty; // [RULE8]
            rdata_d[`CAP_MODE_MSB:`CAP_MODE_LSB] = ctrl_q.mode;
        end else if (hit_result) begin
            rdata_d = fifo_empty ? `CAP_WORD_ZERO : fifo_dout; // [RULE15]
        end else if (hit_event) begin
            rdata_d[`CAP_EV_W-1:0] = ev_q;
        end else if (hit_mask) begin
            rdata_d[`CAP_EV_W-1:0] = mask_q;
        end
    end

    // ****************************************************************
    // APB answer
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `CAP_WORD_ZERO;
        end else if (clk_en) begin
            pready_q <= access;
            pslverr_q <= access & ~hit_any;
            if (access && !pwrite) begin
                prdata_q <= rdata_d;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
endmodule // input_capture_channel

// ===== tb/capture_checker_properties.sv
// Concurrent port checks for the input capture channel.
`timescale 1ns/1ps
`include "capture_defines.svh"
module capture_checker #(
    parameter int DEPTH = `CAP_FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`CAP_ADDR_W-1:0] paddr,
    input wire logic [`CAP_WORD_W-1:0] pwdata,
    input wire logic [`CAP_WORD_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    // ****************************************************************
    // Bus and status relations
    // ****************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_done;
    logic ctrl_rd;
    assign rd_done = pready && !pwrite;
    assign ctrl_rd = rd_done && paddr == `CAP_CTRL_OFS;
    sequence one_wait_then_ready;
        !pready ##1 pready;
    endsequence
    chk_access_one_wait: assert property (psel && $rose(penable) |-> one_wait_then_ready)
        else $error("access phase did not end after one wait state");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_error_map: assert property (pready |-> pslverr == (paddr > `CAP_MASK_OFS || paddr[1:0] != 2'b00))
        else $error("pslverr does not match the address map");
    chk_reset_quiet: assert property ($rose(presetn) |-> !pready && !irq && prdata == 32'h0000_0000)
        else $error("outputs not quiet after reset");
    chk_ctrl_reserved: assert property (ctrl_rd |-> prdata[31:16] == 16'h0000 && !prdata[14] && prdata[12:10] == 3'h0)
        else $error("unused control bits read nonzero");
    chk_event_reserved: assert property (rd_done && paddr == `CAP_EVENT_OFS |-> prdata[31:3] == 29'h0)
        else $error("unused event bits read nonzero");
    chk_overflow_needs_data: assert property (ctrl_rd && prdata[4] |-> prdata[3])
        else $error("overflow flag set with an empty buffer");
    chk_read_data_hold: assert property ($changed(prdata) |-> rd_done)
        else $error("read data changed outside a read");
    chk_irq_disable: assert property (pready && pwrite && paddr == `CAP_CTRL_OFS && !pwdata[15] |-> ##2 !irq)
        else $error("interrupt still high after disable");
endmodule // capture_checker

bind input_capture_channel capture_checker #(.DEPTH(DEPTH)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// ===== tb/input_capture_channel_tb.sv
// Self-checking bench for the input capture channel.
`timescale 1ns/1ps
`include "capture_defines.svh"
module input_capture_channel_tb;
    logic pclk, presetn, psel, penable, pwrite, cpu_idle, cpu_sleep, pready, pslverr, irq, capture_pin, err;
    logic [`CAP_ADDR_W-1:0] paddr;
    logic [`CAP_WORD_W-1:0] pwdata, prdata, rd;
    logic [`CAP_WORD_W-1:0] wide_count = 32'h3333_4444;
    logic [`CAP_HALF_W-1:0] primary_count = 16'h1111;
    logic [`CAP_HALF_W-1:0] secondary_count = 16'h2222;
    logic clk_en = 1'b1;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [31:0] t_ctrl [8] = '{32'h8081, 32'h8002, 32'h8103, 32'h8286, 32'h8086, 32'h8080, 32'h8084, 32'h8085};
    int t_pul [8] = '{2, 2, 2, 2, 2, 2, 8, 16};
    int t_cnt [8] = '{4, 2, 2, 4, 3, 0, 2, 1};
    logic [31:0] t_val [8] = '{32'h1111, 32'h2222, 32'h3333_4444, 32'h1111, 32'h1111, 0, 32'h1111, 32'h1111};

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    input_capture_channel DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_pin(capture_pin), .primary_count(primary_count), .secondary_count(secondary_count),
        .wide_count(wide_count), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq));
    pin_driver src (.capture_pin(capture_pin), .pclk(pclk));

    // ****************************************************************
    // Bus tasks and checks
    // ****************************************************************
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // The slave's latency is not assumed; only the bounded wait ends a hung access.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", 1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        $display("Error watchdog expected done seen timeout");
        test_done();
    end

    initial begin
        {presetn, psel, penable, pwrite, cpu_idle, cpu_sleep} = 6'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            xfer(1'b0, a[11:0], 0);
            check("reset value", 0, rd);
        end
        xfer(1'b1, 12'h010, 32'hffff_ffff);
        check("slverr", 1, err);
        xfer(1'b1, `CAP_RESULT_OFS, 32'h1234);
        check("slverr", 0, err);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, `CAP_CTRL_OFS, 0);
            xfer(1'b1, `CAP_CTRL_OFS, t_ctrl[i]);
            xfer(1'b1, `CAP_CTRL_OFS, 32'h8000);
            src.pulses(t_pul[i]);
            xfer(1'b0, `CAP_CTRL_OFS, 0);
            check("control", t_ctrl[i] | (t_cnt[i] != 0 ? 32'h8 : 32'h0), rd);
            for (int k = 0; k < t_cnt[i]; k++) begin
                xfer(1'b0, `CAP_RESULT_OFS, 0);
                check("result", t_val[i], rd);
            end
            xfer(1'b0, `CAP_CTRL_OFS, 0);
            check("control", t_ctrl[i], rd);
            $display("test mode row %0d done", i);
        end
        xfer(1'b1, `CAP_CTRL_OFS, 0);
        xfer(1'b1, `CAP_CTRL_OFS, 32'h8001);
        src.pulses(3);
        xfer(1'b0, `CAP_CTRL_OFS, 0);
        check("control", 32'h8019, rd);
        xfer(1'b0, `CAP_EVENT_OFS, 0);
        check("event", 32'h3, rd);
        repeat (4) xfer(1'b0, `CAP_RESULT_OFS, 0);
        check("result", 32'h2222, rd);
        xfer(1'b0, `CAP_CTRL_OFS, 0);
        check("control", 32'h8001, rd);
        $display("test overflow done");
        xfer(1'b1, `CAP_MASK_OFS, 32'h1);
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, `CAP_CTRL_OFS, 0);
            xfer(1'b1, `CAP_EVENT_OFS, 32'h7);
            xfer(1'b1, `CAP_CTRL_OFS, 32'h8003 | (c << 5));
            clk_en <= 1'b0;
            src.pulses(1);
            clk_en <= 1'b1;
            src.pulses(c);
            check("irq", 0, irq);
            src.pulses(1);
            check("irq", 1, irq);
        end
        xfer(1'b1, `CAP_MASK_OFS, 0);
        repeat (2) @(posedge pclk);
        check("irq", 0, irq);
        xfer(1'b1, `CAP_MASK_OFS, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq", 1, irq);
        xfer(1'b1, `CAP_CTRL_OFS, 0);
        repeat (2) @(posedge pclk);
        check("irq", 0, irq);
        xfer(1'b0, `CAP_EVENT_OFS, 0);
        check("event", 32'h1, rd);
        xfer(1'b1, `CAP_EVENT_OFS, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq", 0, irq);
        $display("test interrupt done");
        xfer(1'b1, `CAP_CTRL_OFS, 32'ha003);
        cpu_idle <= 1'b1;
        src.pulses(1);
        xfer(1'b0, `CAP_CTRL_OFS, 0);
        check("control", 32'ha003, rd);
        cpu_idle <= 1'b0;
        src.pulses(1);
        xfer(1'b0, `CAP_CTRL_OFS, 0);
        check("control", 32'ha00b, rd);
        xfer(1'b1, `CAP_CTRL_OFS, 0);
        xfer(1'b1, `CAP_MASK_OFS, 32'h4);
        xfer(1'b1, `CAP_CTRL_OFS, 32'h8007);
        src.pulses(1);
        check("irq", 0, irq);
        cpu_sleep <= 1'b1;
        src.pulses(1);
        check("irq", 1, irq);
        xfer(1'b0, `CAP_CTRL_OFS, 0);
        check("control", 32'h8007, rd);
        $display("test idle and edge-only done");
        test_done();
    end
endmodule // input_capture_channel_tb

// ===== tb/pin_driver.sv
// Model of the external digital signal on the capture pin.
`timescale 1ns/1ps
module pin_driver (
    output logic capture_pin,
    input wire logic pclk
);
    // ****************************************************************
    // Edge generation
    // ****************************************************************
    initial capture_pin = 1'b0;
    // Each level is held nine clocks so no edge is missed.
    task automatic drive(input logic v);
        @(posedge pclk);
        capture_pin <= v;
        repeat (8) @(posedge pclk);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            drive(1'b1);
            drive(1'b0);
        end
    endtask
endmodule // pin_driver
